// >>> rtl/wsp_pkg.sv
// Package of register map, field layout and timing constants for the wake sequencer.
//
// Operation
// - With the soft reset wake enable set, a software reset leads back to the on state.
// - With a reset event's wake enable clear, that event leaves the device in standby.
// - The watchdog reset wake enable (bit 5, reset 0) decides if a watchdog reset wakes.
// - The charger present wake enable (bit 4, reset 0) decides if that event wakes.
// - The main battery wake enable (bit 3) decides if a valid main battery event wakes.
// - The first alarm wake enable (bit 2, reset 1) decides if the first alarm wakes.
// - The second alarm wake enable (bit 1, reset 1) decides if the second alarm wakes.
// - The enable pin wake enable (bit 0, reset 1) decides if the enable input wakes.
// - Power-up period bits 6:4 pick 31, 63, 127, 253, 508, 984, 1936 or 3904 us.
// - Power-down period bits 2:0 pick 31, 63, 127, 253, 508, 984, 1936 or 3904 us.
// - A software reset powers both sequencers down and then asserts system reset.
`default_nettype none

package wsp_pkg;

    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned CLK_PERIOD_NS  = 10;

    // Register indices; the byte address is four times the index.
    localparam logic [9:0]  WAKE_IDX       = 10'h094;
    localparam logic [9:0]  PERIOD_IDX     = 10'h095;
    localparam logic [9:0]  CTRL_IDX       = 10'h09a;
    localparam logic [9:0]  STAT_IDX       = 10'h09b;

    localparam logic [7:0]  WAKE_RESET     = 8'h47;
    localparam logic [7:0]  PERIOD_RESET   = 8'h00;
    localparam logic [7:0]  PERIOD_MASK    = 8'h77;

    localparam int unsigned WK_MR_BIT      = 7;
    localparam int unsigned WK_SW_BIT      = 6;
    localparam int unsigned WK_WD_BIT      = 5;
    localparam int unsigned WK_CHG_BIT     = 4;
    localparam int unsigned WK_MB_BIT      = 3;
    localparam int unsigned WK_AL1_BIT     = 2;
    localparam int unsigned WK_AL2_BIT     = 1;
    localparam int unsigned WK_EN_BIT      = 0;
    localparam int unsigned PU_LSB         = 4;
    localparam int unsigned PD_LSB         = 0;
    localparam int unsigned SFT_REQ_BIT    = 0;

    // Slot periods in microseconds, indexed by the 3-bit code.
    localparam logic [11:0] PERIOD_US [8]  = '{12'd31, 12'd63, 12'd127, 12'd253,
                                               12'd508, 12'd984, 12'd1936, 12'd3904};

    localparam int unsigned RESET_PULSE_NS = 1000;
    localparam logic [7:0]  RESET_CYCLES   = 8'(RESET_PULSE_NS / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        ST_STANDBY   = 3'b000,
        ST_POWERUP   = 3'b001,
        ST_ON        = 3'b010,
        ST_POWERDOWN = 3'b011,
        ST_RESET     = 3'b100
    } wsp_state_e;

endpackage

`default_nettype wire

// >>> rtl/wsp_slot_timer.sv
// Slot timer that divides the clock to microseconds and marks the end of each slot period.
`default_nettype none

module wsp_slot_timer
    import wsp_pkg::*;
#(
    parameter int unsigned US_CYCLES = CLK_MHZ
) (
    // Clock and reset.
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Control.
    input  wire logic       run,
    input  wire logic [2:0] period_code,
    // Slot boundary, one cycle.
    output logic            tick
);

    logic [15:0] div_reg;
    logic [11:0] us_reg;
    logic        us_end;

    // The microsecond rate is an enable pulse; the block stays on one clock.
    assign us_end = (div_reg == 16'(US_CYCLES - 1));
    assign tick   = run & us_end & (us_reg == (PERIOD_US[period_code] - 12'h001));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_reg <= 16'h0000;
        end else if (!run || us_end) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            us_reg <= 12'h000;
        end else if (!run || tick) begin
            us_reg <= 12'h000;
        end else if (us_end) begin
            us_reg <= us_reg + 12'h001;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/wsp_wake_sequencer.sv
// Wake source selection, power-up/down slot sequencing and its AHB-Lite register file.
//
// The AHB-Lite slave port was chosen for this implementation.
`default_nettype none

module wsp_wake_sequencer
    import wsp_pkg::*;
#(
    parameter int unsigned US_CYCLES = CLK_MHZ
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Wake event pins.
    input  wire logic        manual_reset_event,
    input  wire logic        watchdog_reset_event,
    input  wire logic        charger_present_event,
    input  wire logic        main_battery_event,
    input  wire logic        first_alarm_event,
    input  wire logic        second_alarm_event,
    input  wire logic        primary_enable_input,
    // Sequencer and system outputs.
    output logic [3:0]       sequencer_a_slots,
    output logic [3:0]       sequencer_b_slots,
    output logic             power_on,
    output logic             system_reset_n
);

    ////////////////////////////////////////////////////////////////////////////////
    logic        wr_pend_reg;
    logic        rd_pend_reg;
    logic        addr_ok_reg;
    logic [9:0]  idx_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_val;
    logic        wr_now;
    logic [7:0]  wake_reg;
    logic [7:0]  period_reg;
    logic        sft_req_reg;
    logic        sft_clr;
    wsp_state_e  state_reg;
    wsp_state_e  state_next;
    logic [7:0]  slots_reg;
    logic [7:0]  rst_cnt_reg;
    logic        rewake_reg;
    logic        rst_n_reg;
    logic        power_on_reg;
    logic        rst_last;
    logic        run;
    logic        tick;
    logic [2:0]  code;
    logic [7:0]  pin_in;
    wire  [7:0]  ev;
    logic        wake_hit;
    logic        shut_req;

    assign hresp     = 1'b0;
    assign hreadyout = ~rd_pend_reg;
    assign hrdata    = hrdata_reg;

    // Reads take one wait state so that a write just before lands first.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_ok_reg <= 1'b0;
            idx_reg     <= 10'h000;
        end else if (hready) begin
            wr_pend_reg <= hsel & htrans[1] & hwrite;
            rd_pend_reg <= hsel & htrans[1] & ~hwrite;
            addr_ok_reg <= (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0)
                           && (hsize == 3'h2);
            idx_reg     <= haddr[11:2];
        end else begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
        end
    end

    assign wr_now = wr_pend_reg & addr_ok_reg;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (addr_ok_reg) begin
            unique case (idx_reg)
                WAKE_IDX:   rd_val = {24'h000000, wake_reg};
                PERIOD_IDX: rd_val = {24'h000000, period_reg};
                CTRL_IDX:   rd_val = {31'h0000_0000, sft_req_reg};
                STAT_IDX:   rd_val = {16'h0000, slots_reg, 5'h00, state_reg};
                default:    rd_val = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            hrdata_reg <= rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_reg <= WAKE_RESET;
        end else if (wr_now && idx_reg == WAKE_IDX) begin
            wake_reg <= hwdata[7:0];
        end
    end

    // Reserved bits are dropped on write and read back as zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_reg <= PERIOD_RESET;
        end else if (wr_now && idx_reg == PERIOD_IDX) begin
            period_reg <= hwdata[7:0] & PERIOD_MASK;
        end
    end

    // A new request wins over the self-clear at the end of the reset pulse.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sft_req_reg <= 1'b0;
        end else if (wr_now && idx_reg == CTRL_IDX && hwdata[SFT_REQ_BIT]) begin
            sft_req_reg <= 1'b1;
        end else if (sft_clr) begin
            sft_req_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign pin_in = {manual_reset_event, 1'b0, watchdog_reset_event,
                     charger_present_event, main_battery_event, first_alarm_event,
                     second_alarm_event, primary_enable_input};

    // Each pin is taken as changed once the second and third stages agree.
    genvar gi;
    for (gi = 0; gi < 8; gi++) begin : g_sync
        if (gi == WK_SW_BIT) begin : g_none
            assign ev[gi] = 1'b0;
        end else begin : g_pin
            logic [2:0] sync_reg;
            logic       level_reg;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync_reg  <= 3'h0;
                    level_reg <= 1'b0;
                end else begin
                    sync_reg <= {sync_reg[1:0], pin_in[gi]};
                    if (sync_reg[1] == sync_reg[2]) begin
                        level_reg <= sync_reg[2];
                    end
                end
            end
            assign ev[gi] = (sync_reg[1] == sync_reg[2]) & sync_reg[2] & ~level_reg;
        end
    end

    // Only enabled sources may wake; the software reset wakes via rewake_reg.
    assign wake_hit = |(ev & wake_reg);
    assign shut_req = sft_req_reg | ev[WK_MR_BIT] | ev[WK_WD_BIT];
    assign rst_last = (rst_cnt_reg == RESET_CYCLES - 8'h01);
    assign sft_clr  = (state_reg == ST_RESET) && rst_last;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_STANDBY: begin
                if (sft_req_reg) begin
                    state_next = ST_POWERDOWN;
                end else if (wake_hit) begin
                    state_next = ST_POWERUP;
                end
            end
            ST_POWERUP: begin
                if (slots_reg == 8'hff) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (shut_req) begin
                    state_next = ST_POWERDOWN;
                end
            end
            ST_POWERDOWN: begin
                if (slots_reg == 8'h00) begin
                    state_next = ST_RESET;
                end
            end
            ST_RESET: begin
                if (rst_last) begin
                    state_next = rewake_reg ? ST_POWERUP : ST_STANDBY;
                end
            end
            default: state_next = ST_STANDBY;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg    <= ST_STANDBY;
            rst_n_reg    <= 1'b1;
            power_on_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            rst_n_reg    <= (state_next != ST_RESET);
            power_on_reg <= (state_next == ST_ON);
        end
    end

    // The cause of the shutdown decides whether the device comes back on.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rewake_reg <= 1'b0;
        end else if (state_next == ST_POWERDOWN && state_reg != ST_POWERDOWN) begin
            if (sft_req_reg) begin
                rewake_reg <= wake_reg[WK_SW_BIT];
            end else if (ev[WK_MR_BIT]) begin
                rewake_reg <= wake_reg[WK_MR_BIT];
            end else begin
                rewake_reg <= wake_reg[WK_WD_BIT];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_cnt_reg <= 8'h00;
        end else if (state_reg == ST_RESET) begin
            rst_cnt_reg <= rst_cnt_reg + 8'h01;
        end else begin
            rst_cnt_reg <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Slots 3:0 belong to sequencer a and 7:4 to sequencer b; b goes down first.
    assign run  = ((state_reg == ST_POWERUP) && (slots_reg != 8'hff))
                  || ((state_reg == ST_POWERDOWN) && (slots_reg != 8'h00));
    assign code = (state_reg == ST_POWERUP) ? period_reg[PU_LSB +: 3]
                                            : period_reg[PD_LSB +: 3];

    wsp_slot_timer #(
        .US_CYCLES   (US_CYCLES)
    ) u_timer (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .run         (run),
        .period_code (code),
        .tick        (tick)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slots_reg <= 8'h00;
        end else if (tick && state_reg == ST_POWERUP) begin
            slots_reg <= {slots_reg[6:0], 1'b1};
        end else if (tick && state_reg == ST_POWERDOWN) begin
            slots_reg <= {1'b0, slots_reg[7:1]};
        end
    end

    assign sequencer_a_slots = slots_reg[3:0];
    assign sequencer_b_slots = slots_reg[7:4];
    assign power_on          = power_on_reg;
    assign system_reset_n    = rst_n_reg;

    ////////////////////////////////////////////////////////////////////////////////
    logic [31:0] gap_reg;
    logic [31:0] gap_want;

    assign gap_want = 32'(PERIOD_US[code]) * 32'(US_CYCLES) - 32'h0000_0001;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_reg <= 32'h0000_0000;
        end else if (!run || tick) begin
            gap_reg <= 32'h0000_0000;
        end else begin
            gap_reg <= gap_reg + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_sw_rewake_on: assert property (
        (state_reg == ST_RESET && rst_last && rewake_reg) |=> state_reg == ST_POWERUP)
        else $error("software reset with wake enabled did not restart power-up");
    a_sw_rewake_src: assert property (
        (state_reg == ST_ON && sft_req_reg) |=> rewake_reg == $past(wake_reg[WK_SW_BIT]))
        else $error("rewake not taken from the soft reset wake enable");
    a_stay_standby: assert property (
        (state_reg == ST_RESET && rst_last && !rewake_reg) |=> state_reg == ST_STANDBY
        ##1 (state_reg == ST_STANDBY || $past(wake_hit) || $past(sft_req_reg)))
        else $error("device left standby after a reset without wake");
    a_wd_wake: assert property (
        (state_reg == ST_STANDBY && !sft_req_reg && ev[WK_WD_BIT] && wake_reg[WK_WD_BIT])
        |=> state_reg == ST_POWERUP)
        else $error("enabled watchdog reset did not wake");
    a_chg_wake: assert property (
        (state_reg == ST_STANDBY && !sft_req_reg && ev == 8'h10)
        |=> (state_reg == ST_POWERUP) == $past(wake_reg[WK_CHG_BIT]))
        else $error("charger present wake does not follow its enable");
    a_mb_wake: assert property (
        (state_reg == ST_STANDBY && !sft_req_reg && ev == 8'h08)
        |=> (state_reg == ST_POWERUP) == $past(wake_reg[WK_MB_BIT]))
        else $error("main battery wake does not follow its enable");
    a_al1_wake: assert property (
        (state_reg == ST_STANDBY && !sft_req_reg && ev == 8'h04)
        |=> (state_reg == ST_POWERUP) == $past(wake_reg[WK_AL1_BIT]))
        else $error("first alarm wake does not follow its enable");
    a_al2_wake: assert property (
        (state_reg == ST_STANDBY && !sft_req_reg && ev == 8'h02)
        |=> (state_reg == ST_POWERUP) == $past(wake_reg[WK_AL2_BIT]))
        else $error("second alarm wake does not follow its enable");
    a_en_wake: assert property (
        (state_reg == ST_STANDBY && !sft_req_reg && ev == 8'h01)
        |=> (state_reg == ST_POWERUP) == $past(wake_reg[WK_EN_BIT]))
        else $error("enable pin wake does not follow its enable");
    a_pu_spacing: assert property (
        (tick && state_reg == ST_POWERUP) |-> gap_reg == gap_want)
        else $error("power-up slot spacing differs from the selected period");
    a_pd_spacing: assert property (
        (tick && state_reg == ST_POWERDOWN) |-> gap_reg == gap_want)
        else $error("power-down slot spacing differs from the selected period");
    a_sw_shutdown: assert property (
        (state_reg == ST_ON && sft_req_reg) |=> state_reg == ST_POWERDOWN)
        else $error("software reset did not start the shutdown");
    a_pd_to_reset: assert property (
        (state_reg == ST_POWERDOWN && slots_reg == 8'h00)
        |=> (state_reg == ST_RESET && !system_reset_n))
        else $error("finished power-down did not assert system reset");
    a_mr_wake: assert property (
        (state_reg == ST_STANDBY && !sft_req_reg && ev[WK_MR_BIT] && wake_reg[WK_MR_BIT])
        |=> state_reg == ST_POWERUP)
        else $error("enabled manual reset did not wake");
    a_pu_order: assert property (
        (tick && state_reg == ST_POWERUP) |=> slots_reg == {$past(slots_reg[6:0]), 1'b1})
        else $error("power-up slot did not advance on the period tick");

endmodule

`default_nettype wire

// >>> bench/wsp_wake_sequencer_tb_top.sv
// Self-checking testbench for wake source selection, slot timing and shutdown.
`default_nettype none

module wsp_wake_sequencer_tb_top
    import wsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] A_WAKE = {20'h0, WAKE_IDX, 2'b00};
    localparam logic [31:0] A_PER  = {20'h0, PERIOD_IDX, 2'b00};
    localparam logic [31:0] A_CTRL = {20'h0, CTRL_IDX, 2'b00};
    localparam logic [31:0] A_STAT = {20'h0, STAT_IDX, 2'b00};
    // Slot spacing in cycles, with the timer shortened to one clock per microsecond.
    localparam int          P_CYC [8] = '{31, 63, 127, 253, 508, 984, 1936, 3904};

    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b1;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    logic [7:0]  ev      = 8'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [3:0]  slot_a;
    logic [3:0]  slot_b;
    logic        power_on;
    logic        system_reset_n;
    int          bad_count = 0;
    int          compares  = 0;
    wire  [5:0]  mon = {slot_b[2], slot_b[3], slot_a[1], slot_a[0], system_reset_n, power_on};

    ////////////////////////////////////////////////////////////////////////////////
    wsp_wake_sequencer #(.US_CYCLES(1)) wsp_wake_sequencer_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .manual_reset_event(ev[7]), .watchdog_reset_event(ev[5]),
        .charger_present_event(ev[4]), .main_battery_event(ev[3]),
        .first_alarm_event(ev[2]), .second_alarm_event(ev[1]),
        .primary_enable_input(ev[0]), .sequencer_a_slots(slot_a),
        .sequencer_b_slots(slot_b), .power_on(power_on), .system_reset_n(system_reset_n)
    );

    always #5 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    task automatic give_up(input string name);
        $display("Error %s expected done seen timeout", name);
        bad_count++;
        results();
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Samples are taken before each edge's updates land, so n counts whole cycles.
    task automatic wait_mon(input int which, input logic lvl, input int lim, output int n);
        n = 0;
        while (mon[which] !== lvl) begin
            @(posedge hclk);
            n++;
            if (n > lim) give_up("wait");
        end
    endtask

    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
            n++;
            if (n > 16) give_up("hready");
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd);
        haddr  <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] addr, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, addr, {24'h0, d}, r);
    endtask

    task automatic rd_chk(input string name, input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, addr, 32'h0, r);
        check(name, exp, r);
        check("hresp", 32'h0, {31'h0, hresp});
    endtask

    // Pins are held well past the synchroniser depth so each rise is seen once.
    task automatic pulse(input int idx);
        ev[idx] <= 1'b1;
        tick(6);
        ev[idx] <= 1'b0;
        tick(4);
    endtask

    task automatic wake_on;
        int n;
        pulse(0);
        wait_mon(0, 1'b1, 40000, n);
        check("slots_on", 32'hff, {24'h0, slot_b, slot_a});
    endtask

    // A negative cause shuts down by software request, otherwise by that event pin.
    task automatic go_off(input int cause, input logic rewake, input int pd);
        int n;
        if (cause < 0) begin
            wr(A_CTRL, 8'h01);
        end else begin
            pulse(cause);
        end
        wait_mon(4, 1'b0, 5000, n);
        wait_mon(5, 1'b0, 5000, n);
        check("pd_spacing", pd, n);
        wait_mon(1, 1'b0, 40000, n);
        check("slots_at_reset", 32'h0, {24'h0, slot_b, slot_a});
        wait_mon(1, 1'b1, 1000, n);
        check("reset_len", {24'h0, RESET_CYCLES}, n);
        if (rewake) begin
            wait_mon(0, 1'b1, 40000, n);
            check("rewake_slots", 32'hff, {24'h0, slot_b, slot_a});
        end else begin
            tick(40);
            rd_chk("standby_state", A_STAT, 32'h0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd_chk("wake_reset", A_WAKE, 32'h47);
        rd_chk("period_reset", A_PER, 32'h0);
        wr(A_PER, 8'h77);
        rd_chk("period_rw", A_PER, 32'h77);
        wr(A_WAKE, 8'hb8);
        rd_chk("wake_rw", A_WAKE, 32'hb8);
        wr(32'h0000_0300, 8'h5a);
        rd_chk("unmapped", 32'h0000_0300, 32'h0);
        wr(A_PER, 8'h00);
    endtask

    task automatic t_events;
        int i;
        int n;
        for (i = 0; i < 8; i++) begin
            if (i == WK_SW_BIT) continue;
            wr(A_WAKE, 8'h00);
            pulse(i);
            tick(300);
            check("no_wake", 32'h0, {31'h0, power_on});
            rd_chk("no_wake_state", A_STAT, 32'h0);
            wr(A_WAKE, 8'(1 << i));
            pulse(i);
            rd_chk("wake_state", A_STAT, 32'h1);
            wait_mon(0, 1'b1, 40000, n);
            check("slots_on", 32'hff, {24'h0, slot_b, slot_a});
            go_off(-1, 1'b0, 31);
        end
    endtask

    // The last part requests a software reset from standby: an empty shutdown, then reset.
    task automatic t_soft;
        int n;
        wr(A_WAKE, 8'h41);
        wake_on();
        go_off(-1, 1'b1, 31);
        wr(A_WAKE, 8'h01);
        go_off(-1, 1'b0, 31);
        wr(A_WAKE, 8'h41);
        wr(A_CTRL, 8'h01);
        wait_mon(1, 1'b0, 200, n);
        wait_mon(1, 1'b1, 1000, n);
        check("standby_reset_len", {24'h0, RESET_CYCLES}, n);
        wait_mon(0, 1'b1, 40000, n);
        check("standby_rewake", 32'hff, {24'h0, slot_b, slot_a});
    endtask

    task automatic t_on_reset;
        wr(A_WAKE, 8'h21);
        wake_on();
        go_off(WK_WD_BIT, 1'b1, 31);
        wr(A_WAKE, 8'h81);
        go_off(WK_MR_BIT, 1'b1, 31);
        wr(A_WAKE, 8'h01);
        go_off(WK_WD_BIT, 1'b0, 31);
        wake_on();
        go_off(WK_MR_BIT, 1'b0, 31);
    endtask

    // Power-down codes are limited to the four short ones to keep the run bounded.
    task automatic t_periods;
        int c;
        int n;
        wr(A_WAKE, 8'h01);
        for (c = 0; c < 8; c++) begin
            wr(A_PER, {1'b0, 3'(c), 1'b0, 3'(c & 3)});
            pulse(0);
            wait_mon(2, 1'b1, 5000, n);
            wait_mon(3, 1'b1, 5000, n);
            check("pu_spacing", 32'(P_CYC[c]), n);
            wait_mon(0, 1'b1, 40000, n);
            go_off(-1, 1'b0, P_CYC[c & 3]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_events();
        t_soft();
        t_on_reset();
        t_periods();
        results();
    end

endmodule

`default_nettype wire
